/* File: pkg/lcdgd_pkg.sv */
// Package of offsets, fields, reset values and timing constants for the LCD glass driver
`default_nettype none
package lcdgd_pkg;

  // Register byte offsets
  localparam logic [7:0] LCDGD_OFS_CTRL0  = 8'h00;  // display_control_zero
  localparam logic [7:0] LCDGD_OFS_CTRL1  = 8'h04;  // display_control_one
  localparam logic [7:0] LCDGD_OFS_PINA   = 8'h08;  // pin_function_select_a
  localparam logic [7:0] LCDGD_OFS_PINB   = 8'h0c;  // pin_function_select_b
  localparam logic [7:0] LCDGD_OFS_STAT   = 8'h10;  // status
  localparam logic [7:0] LCDGD_OFS_DATA0  = 8'h20;  // first display data word
  localparam int         LCDGD_DATA_WORDS = 10;     // four frontplanes per word

  // display_control_zero fields
  localparam int LCDGD_C0_ENABLE  = 0;
  localparam int LCDGD_C0_DUTY_LO = 1;   // 3 bits
  localparam int LCDGD_C0_BIAS    = 4;   // 0: one-third, 1: one-half
  localparam int LCDGD_C0_STR_LO  = 5;   // 3 bits
  localparam int LCDGD_C0_PUMP    = 8;
  localparam int LCDGD_C0_PCLK_LO = 9;   // 2 bits
  localparam logic [31:0] LCDGD_C0_MASK  = 32'h0000_07ff;
  localparam logic [31:0] LCDGD_C0_RESET = 32'h0000_0000;

  // display_control_one fields
  localparam int LCDGD_C1_CLKSRC  = 0;   // 0: internal, 1: external oscillator
  localparam int LCDGD_C1_RATE_LO = 1;   // 2 bits
  localparam int LCDGD_C1_FRAMEIE = 3;
  localparam logic [31:0] LCDGD_C1_MASK  = 32'h0000_000f;
  localparam logic [31:0] LCDGD_C1_RESET = 32'h0000_0000;

  // Pin function fields
  localparam int LCDGD_PA_SHARED_BIAS_LO = 24;
  localparam int LCDGD_PA_SHARED_BP_LO   = 28;
  localparam int LCDGD_PB_BP_LO          = 24;
  localparam int LCDGD_PB_GROUP          = 28;  // bias_pin_group_enable
  localparam logic [31:0] LCDGD_PB_MASK  = 32'h1f00_00ff;
  localparam logic [31:0] LCDGD_PIN_RESET = 32'h0000_0000;

  // Status fields
  localparam int LCDGD_ST_FRAME = 0;
  localparam int LCDGD_ST_RUN   = 1;

  // Duty codes
  localparam logic [2:0] LCDGD_DUTY_STATIC = 3'h0;
  localparam logic [2:0] LCDGD_DUTY_HALF   = 3'h1;
  localparam logic [2:0] LCDGD_DUTY_THIRD  = 3'h2;
  localparam logic [2:0] LCDGD_DUTY_QUART  = 3'h3;
  localparam logic [2:0] LCDGD_DUTY_SIXTH  = 3'h5;
  localparam logic [2:0] LCDGD_DUTY_EIGHTH = 3'h7;

  // Ladder strength: 000 means external bias network
  localparam logic [2:0] LCDGD_STR_EXTERNAL = 3'h0;

  // Drive level codes: ground, first step, second step, top
  localparam logic [1:0] LCDGD_LVL_V0 = 2'h0;
  localparam logic [1:0] LCDGD_LVL_V1 = 2'h1;
  localparam logic [1:0] LCDGD_LVL_V2 = 2'h2;
  localparam logic [1:0] LCDGD_LVL_V3 = 2'h3;

  // Working clock and scan frequencies in Hz
  localparam int LCDGD_SLOW_HZ   = 32768;
  localparam int LCDGD_SCAN_HZ_0 = 128;
  localparam int LCDGD_SCAN_HZ_1 = 256;
  localparam int LCDGD_SCAN_HZ_2 = 512;
  localparam int LCDGD_SCAN_HZ_3 = 64;
  // Slow ticks per half strobe period; polarity flips at each half
  localparam logic [8:0] LCDGD_HALF_0 = 9'(LCDGD_SLOW_HZ / (2 * LCDGD_SCAN_HZ_0));
  localparam logic [8:0] LCDGD_HALF_1 = 9'(LCDGD_SLOW_HZ / (2 * LCDGD_SCAN_HZ_1));
  localparam logic [8:0] LCDGD_HALF_2 = 9'(LCDGD_SLOW_HZ / (2 * LCDGD_SCAN_HZ_2));
  localparam logic [8:0] LCDGD_HALF_3 = 9'(LCDGD_SLOW_HZ / (2 * LCDGD_SCAN_HZ_3));

  // Scan sequencer states
  typedef enum logic [1:0] {
    LCDGD_ST_IDLE = 2'b01,
    LCDGD_ST_SCAN = 2'b10
  } lcdgd_state_t;

endpackage
`default_nettype wire

/* File: logic/lcdgd_top.sv */
// LCD glass driver: APB registers, slow-clock scan sequencer and pin drive levels
//
// The APB slave port and the register addresses were chosen for this implementation.
`default_nettype none

// Contract
// R1 - Working clock from internal or external oscillator
// R2 - Scan rate field picks 64-512 Hz
// R3 - Frame strobes every active backplane once
// R4 - Bias field picks one-third or one-half
// R5 - Software clears bias for static drive
// R6 - Strength field sets internal ladder current
// R7 - Strength 000 disconnects ladder, external bias
// R8 - Internal ladder frees bias pins as frontplanes
// R9 - Software enables pump only for capacitors
// R10 - Duty field encodes active backplane count
// R11 - Software pairs bias with duty sensibly
// R12 - Alternating drive, no lasting DC
// R13 - Pin select b bits 24-27 enable backplanes
// R14 - Shared pins 28-31 role set by duty
// R15 - Group enable gives bias pins display role
// R16 - Group pins: bias inputs or frontplanes 24-27
// R17 - Pin select a bits 24-27 per pin
// R18 - Pin select a bits 0-23 enable frontplanes
// R19 - At most eight backplanes, forty frontplanes
// R20 - Software raises scan rate with more backplanes
// R21 - Frame refresh can raise an event
// R22 - Backplanes strobed ascending, frontplanes follow
module lcdgd_top
  import lcdgd_pkg::*;
#(
  parameter int NUM_BP = 8,
  parameter int NUM_FP = 40
) (
  // Clock and reset
  input  wire logic                  clk_in,
  input  wire logic                  reset_n_in,
  // APB slave
  input  wire logic                  psel_in,
  input  wire logic                  penable_in,
  input  wire logic                  pwrite_in,
  input  wire logic [7:0]            paddr_in,
  input  wire logic [31:0]           pwdata_in,
  output logic      [31:0]           prdata_out,
  output logic                       pready_out,
  output logic                       pslverr_out,
  // Slow oscillators
  input  wire logic                  internal_slow_oscillator_in,
  input  wire logic                  external_slow_oscillator_in,
  // Glass drive
  output logic      [2*NUM_BP-1:0]   bp_level_out,
  output logic      [NUM_BP-1:0]     bp_enable_out,
  output logic      [2*NUM_FP-1:0]   fp_level_out,
  output logic      [NUM_FP-1:0]     fp_enable_out,
  // Bias network control
  output logic      [3:0]            bias_pin_input_out,
  output logic                       ladder_connect_out,
  output logic      [2:0]            ladder_strength_out,
  output logic                       bias_half_out,
  output logic                       charge_pump_enable_out,
  output logic      [1:0]            pump_clock_select_out,
  // Frame event
  output logic                       frame_done_out
);

  // Register storage
  logic [31:0]  ctrl0_ff;
  logic [31:0]  ctrl1_ff;
  logic [31:0]  pina_ff;
  logic [31:0]  pinb_ff;
  logic [31:0]  data_ff [LCDGD_DATA_WORDS];
  logic         frame_flag_ff;
  logic [31:0]  prdata_ff;
  logic         pready_ff;
  logic         pslverr_ff;

  // Oscillator sampling
  logic [1:0]   int_sync_ff;
  logic [1:0]   ext_sync_ff;
  logic         osc_prev_ff;
  logic         osc_level;
  logic         slow_tick;

  // Scan state
  lcdgd_state_t state_ff;
  logic [8:0]   half_cnt_ff;
  logic [2:0]   bp_idx_ff;
  logic         phase_ff;
  logic         frame_done_ff;

  // Decoded control
  logic [2:0]   duty;
  logic [3:0]   active_bp;
  logic         duty_ok;
  logic         run;
  logic         bias_half;
  logic         external_bias;
  logic         static_mode;
  logic [8:0]   half_len;
  logic         half_end;
  logic         frame_end;

  // APB decode
  logic         wr_en;
  logic         rd_phase;
  logic         addr_map;
  logic [31:0]  rd_mux;
  logic [3:0]   data_idx;
  logic         data_hit;

  // Drive level registers
  logic [2*NUM_BP-1:0] bp_level_ff;
  logic [NUM_BP-1:0]   bp_enable_ff;
  logic [2*NUM_FP-1:0] fp_level_ff;
  logic [NUM_FP-1:0]   fp_enable_ff;
  logic [3:0]          bias_in_ff;

  assign duty          = ctrl0_ff[LCDGD_C0_DUTY_LO +: 3];
  assign bias_half     = ctrl0_ff[LCDGD_C0_BIAS];
  assign static_mode   = (duty == LCDGD_DUTY_STATIC);
  // R7 ladder disconnect
  assign external_bias = (ctrl0_ff[LCDGD_C0_STR_LO +: 3] == LCDGD_STR_EXTERNAL);

  // R10 duty decode; reserved codes leave the glass idle
  always_comb begin
    duty_ok = 1'b1;
    case (duty)
      LCDGD_DUTY_STATIC: active_bp = 4'h1;
      LCDGD_DUTY_HALF:   active_bp = 4'h2;
      LCDGD_DUTY_THIRD:  active_bp = 4'h3;
      LCDGD_DUTY_QUART:  active_bp = 4'h4;
      LCDGD_DUTY_SIXTH:  active_bp = 4'h6;
      LCDGD_DUTY_EIGHTH: active_bp = 4'h8;
      default: begin
        active_bp = 4'h0;
        duty_ok   = 1'b0;
      end
    endcase
  end

  assign run = ctrl0_ff[LCDGD_C0_ENABLE] & duty_ok;

  // R2 scan rate to half strobe length in slow ticks
  always_comb begin
    case (ctrl1_ff[LCDGD_C1_RATE_LO +: 2])
      2'h0:    half_len = LCDGD_HALF_0;
      2'h1:    half_len = LCDGD_HALF_1;
      2'h2:    half_len = LCDGD_HALF_2;
      default: half_len = LCDGD_HALF_3;
    endcase
  end

  // Oscillator pins cross into this domain through two flops each
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      int_sync_ff <= 2'h0;
      ext_sync_ff <= 2'h0;
      osc_prev_ff <= 1'b0;
    end else begin
      int_sync_ff <= {int_sync_ff[0], internal_slow_oscillator_in};
      ext_sync_ff <= {ext_sync_ff[0], external_slow_oscillator_in};
      osc_prev_ff <= osc_level;
    end
  end

  // R1 source select; a switch may cost or add one slow tick
  assign osc_level = ctrl1_ff[LCDGD_C1_CLKSRC] ? ext_sync_ff[1] : int_sync_ff[1];

  // Rising edge of the slow clock gives a one-cycle enable
  assign slow_tick = osc_level & ~osc_prev_ff;
  assign half_end  = slow_tick & (half_cnt_ff >= half_len - 9'h1);  // A shorter rate ends the half, no wrap
  assign frame_end = half_end & phase_ff & ({1'b0, bp_idx_ff} == active_bp - 4'h1);

  // R3 scan sequencer: one frame visits every active backplane
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_ff    <= LCDGD_ST_IDLE;
      half_cnt_ff <= 9'h0;
      bp_idx_ff   <= 3'h0;
      phase_ff    <= 1'b0;
    end else begin
      case (state_ff)
        LCDGD_ST_IDLE: begin
          half_cnt_ff <= 9'h0;
          bp_idx_ff   <= 3'h0;
          phase_ff    <= 1'b0;
          if (run) begin
            state_ff <= LCDGD_ST_SCAN;
          end
        end
        LCDGD_ST_SCAN: begin
          if (!run) begin
            state_ff <= LCDGD_ST_IDLE;
          end else if (half_end) begin
            half_cnt_ff <= 9'h0;
            // R12 polarity flips every half strobe
            phase_ff    <= ~phase_ff;
            if (phase_ff) begin
              // R22 ascending strobe order
              bp_idx_ff <= frame_end ? 3'h0 : bp_idx_ff + 3'h1;
            end
          end else if (slow_tick) begin
            half_cnt_ff <= half_cnt_ff + 9'h1;
          end
        end
        default: state_ff <= LCDGD_ST_IDLE;
      endcase
    end
  end

  // R21 frame refresh pulse, gated by its enable
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      frame_done_ff <= 1'b0;
    end else begin
      frame_done_ff <= (state_ff == LCDGD_ST_SCAN) & run & frame_end & ctrl1_ff[LCDGD_C1_FRAMEIE];
    end
  end

  // Backplane levels and pin roles
  generate
    for (genvar b = 0; b < NUM_BP; b++) begin : g_bp
      logic [1:0] lvl;
      logic       pin_on;
      // R19 shared backplanes above the duty count stay frontplanes; dedicated ones above it are disabled
      if (b < 4) begin : g_ded
        // R13 dedicated backplane enables
        assign pin_on = pinb_ff[LCDGD_PB_BP_LO + b];
      end else begin : g_shr
        // R14 shared pin is a backplane only inside the duty count
        assign pin_on = pina_ff[LCDGD_PA_SHARED_BP_LO + 7 - b] & (active_bp > 4'(b));
      end
      // R12 selected swings full range; unselected alternates middle taps so no DC is left
      always_comb begin
        if (bp_idx_ff == 3'(b)) begin
          lvl = phase_ff ? LCDGD_LVL_V0 : LCDGD_LVL_V3;
        end else begin
          lvl = phase_ff ? LCDGD_LVL_V2 : LCDGD_LVL_V1;
        end
      end
      always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          bp_level_ff[2*b +: 2] <= LCDGD_LVL_V0;
          bp_enable_ff[b]       <= 1'b0;
        end else begin
          bp_level_ff[2*b +: 2] <= (state_ff == LCDGD_ST_SCAN) ? lvl : LCDGD_LVL_V0;
          bp_enable_ff[b]       <= pin_on & (b < active_bp) & run;
        end
      end
    end
  endgenerate

  // Frontplane levels and pin roles
  generate
    for (genvar f = 0; f < NUM_FP; f++) begin : g_fp
      logic [1:0] lvl;
      logic       pix;
      logic       pin_on;
      // R22 pixel of this frontplane at the current strobe
      assign pix = data_ff[f / 4][8 * (f % 4) + int'(bp_idx_ff)];
      if (f < 24) begin : g_plain
        // R18 plain frontplane enables
        assign pin_on = pina_ff[f];
      end else if (f < 28) begin : g_bias
        // R8 R15 R16 R17 shared bias pin is a frontplane on internal ladder
        assign pin_on = pina_ff[f] & pinb_ff[LCDGD_PB_GROUP] & ~external_bias;
      end else if (f < 32) begin : g_shr
        // R14 pin serves as frontplane when its backplane is unused
        assign pin_on = pina_ff[f] & (active_bp <= 4'(35 - f));
      end else begin : g_high
        assign pin_on = pinb_ff[f - 32];
      end
      // R4 R12 lit pixels oppose the selected backplane, dark ones follow it
      always_comb begin
        if (pix) begin
          lvl = phase_ff ? LCDGD_LVL_V3 : LCDGD_LVL_V0;
        end else if (bias_half || static_mode) begin
          lvl = phase_ff ? LCDGD_LVL_V0 : LCDGD_LVL_V3;
        end else begin
          lvl = phase_ff ? LCDGD_LVL_V1 : LCDGD_LVL_V2;
        end
      end
      always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          fp_level_ff[2*f +: 2] <= LCDGD_LVL_V0;
          fp_enable_ff[f]       <= 1'b0;
        end else begin
          fp_level_ff[2*f +: 2] <= (state_ff == LCDGD_ST_SCAN) ? lvl : LCDGD_LVL_V0;
          fp_enable_ff[f]       <= pin_on & run;
        end
      end
    end
  endgenerate

  // R16 shared pins take bias levels when the group is enabled and an external network is used
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      bias_in_ff <= 4'h0;
    end else begin
      bias_in_ff <= pina_ff[LCDGD_PA_SHARED_BIAS_LO +: 4] & {4{pinb_ff[LCDGD_PB_GROUP] & external_bias}};
    end
  end

  // APB: one wait state so read data comes from a flop
  assign rd_phase = psel_in & penable_in & ~pready_ff;
  assign wr_en    = psel_in & penable_in & pready_ff & pwrite_in & ~pslverr_ff;
  assign data_idx = 4'((paddr_in - LCDGD_OFS_DATA0) >> 2);
  assign data_hit = (paddr_in[1:0] == 2'h0) && (paddr_in >= LCDGD_OFS_DATA0)
                    && (data_idx < 4'(LCDGD_DATA_WORDS));

  // Read mux and map check
  always_comb begin
    addr_map = 1'b1;
    rd_mux   = 32'h0;
    if (data_hit) begin
      rd_mux = data_ff[data_idx];
    end else begin
      case (paddr_in)
        LCDGD_OFS_CTRL0: rd_mux = ctrl0_ff;
        LCDGD_OFS_CTRL1: rd_mux = ctrl1_ff;
        LCDGD_OFS_PINA:  rd_mux = pina_ff;
        LCDGD_OFS_PINB:  rd_mux = pinb_ff;
        LCDGD_OFS_STAT:  rd_mux = {30'h0, state_ff == LCDGD_ST_SCAN, frame_flag_ff};
        default:         addr_map = 1'b0;
      endcase
    end
  end

  // Answer timing
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0;
    end else begin
      pready_ff  <= rd_phase;
      pslverr_ff <= rd_phase & ~addr_map;
      if (rd_phase) begin
        prdata_ff <= (pwrite_in || !addr_map) ? 32'h0 : rd_mux;
      end
    end
  end

  // Control registers; R5 R9 R11 R20 are left to software
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctrl0_ff <= LCDGD_C0_RESET;
      ctrl1_ff <= LCDGD_C1_RESET;
      pina_ff  <= LCDGD_PIN_RESET;
      pinb_ff  <= LCDGD_PIN_RESET;
    end else if (wr_en) begin
      case (paddr_in)
        LCDGD_OFS_CTRL0: ctrl0_ff <= pwdata_in & LCDGD_C0_MASK;
        LCDGD_OFS_CTRL1: ctrl1_ff <= pwdata_in & LCDGD_C1_MASK;
        LCDGD_OFS_PINA:  pina_ff  <= pwdata_in;
        LCDGD_OFS_PINB:  pinb_ff  <= pwdata_in & LCDGD_PB_MASK;
        default: ;
      endcase
    end
  end

  // Display data words
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      for (int i = 0; i < LCDGD_DATA_WORDS; i++) begin
        data_ff[i] <= 32'h0;
      end
    end else if (wr_en && data_hit) begin
      data_ff[data_idx] <= pwdata_in;
    end
  end

  // R21 sticky frame flag: writing 0 clears, a new frame wins over the clear
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      frame_flag_ff <= 1'b0;
    end else if ((state_ff == LCDGD_ST_SCAN) && run && frame_end) begin
      frame_flag_ff <= 1'b1;
    end else if (wr_en && paddr_in == LCDGD_OFS_STAT && !pwdata_in[LCDGD_ST_FRAME]) begin
      frame_flag_ff <= 1'b0;
    end
  end

  // Outputs straight from flops, except ladder_connect_out
  assign prdata_out             = prdata_ff;
  assign pready_out             = pready_ff;
  assign pslverr_out            = pslverr_ff;
  assign bp_level_out           = bp_level_ff;
  assign bp_enable_out          = bp_enable_ff;
  assign fp_level_out           = fp_level_ff;
  assign fp_enable_out          = fp_enable_ff;
  assign bias_pin_input_out     = bias_in_ff;
  // R6 R7 ladder strength straight from the register; connection needs the enable bit and a nonzero strength
  assign ladder_strength_out    = ctrl0_ff[LCDGD_C0_STR_LO +: 3];
  assign ladder_connect_out     = ctrl0_ff[LCDGD_C0_ENABLE] & (ctrl0_ff[LCDGD_C0_STR_LO +: 3] != 3'h0);
  assign bias_half_out          = ctrl0_ff[LCDGD_C0_BIAS];
  assign charge_pump_enable_out = ctrl0_ff[LCDGD_C0_PUMP];
  assign pump_clock_select_out  = ctrl0_ff[LCDGD_C0_PCLK_LO +: 2];
  assign frame_done_out         = frame_done_ff;

endmodule
`default_nettype wire

/* File: sim/lcdgd_chk.sv */
// Assertion checker for the LCD glass driver top-level ports
`default_nettype none
module lcdgd_chk
  import lcdgd_pkg::*;
#(
  parameter int NUM_BP = 8,
  parameter int NUM_FP = 40
) (
  // Clock, reset and bus
  input wire logic                clk_in,
  input wire logic                reset_n_in,
  input wire logic                psel_in,
  input wire logic                penable_in,
  input wire logic                pready_out,
  input wire logic                pslverr_out,
  // Glass and bias network
  input wire logic [2*NUM_BP-1:0] bp_level_out,
  input wire logic [NUM_BP-1:0]   bp_enable_out,
  input wire logic [NUM_FP-1:0]   fp_enable_out,
  input wire logic [3:0]          bias_pin_input_out,
  input wire logic                ladder_connect_out,
  input wire logic [2:0]          ladder_strength_out,
  input wire logic                frame_done_out
);
  logic [NUM_BP-1:0] sel;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  // Only a strobed backplane in its first phase sits at the top level
  always_comb begin
    for (int b = 0; b < NUM_BP; b++) begin
      sel[b] = bp_level_out[2*b+:2] == LCDGD_LVL_V3;
    end
  end
  a_wait_state: assert property (psel_in && penable_in && !$past(penable_in) |-> !pready_out ##1 pready_out)
    else $error("ready not one cycle after access start");
  a_err_ready: assert property (pslverr_out |-> pready_out)
    else $error("error without ready");
  a_ladder_strength: assert property (ladder_connect_out |-> ladder_strength_out != LCDGD_STR_EXTERNAL)
    else $error("ladder connected with external strength code");
  a_bias_src: assert property (|bias_pin_input_out |-> ladder_strength_out == LCDGD_STR_EXTERNAL)
    else $error("bias inputs while ladder selected");
  a_bias_role: assert property ((bias_pin_input_out & fp_enable_out[27:24]) == 4'h0)
    else $error("shared bias pin in two roles");
  a_shared_role: assert property ((bp_enable_out[7:4] & {fp_enable_out[28], fp_enable_out[29],
    fp_enable_out[30], fp_enable_out[31]}) == 4'h0)
    else $error("shared plane pin in two roles");
  a_one_strobe: assert property ($onehot0(sel))
    else $error("two backplanes strobed at once");
  a_phase_flip: assert property ($fell(sel[0]) |-> bp_level_out[1:0] == LCDGD_LVL_V0)
    else $error("first backplane did not invert");
  a_order_step: assert property ($rose(sel[1]) |-> $past(bp_level_out[1:0]) == LCDGD_LVL_V0)
    else $error("second backplane not after the first");
  a_frame_pulse: assert property (frame_done_out |=> !frame_done_out [*8])
    else $error("frame event longer than one cycle");
endmodule

bind lcdgd_top lcdgd_chk #(.NUM_BP(NUM_BP), .NUM_FP(NUM_FP)) u_chk (
  .clk_in(clk_in), .reset_n_in(reset_n_in), .psel_in(psel_in), .penable_in(penable_in),
  .pready_out(pready_out), .pslverr_out(pslverr_out), .bp_level_out(bp_level_out),
  .bp_enable_out(bp_enable_out), .fp_enable_out(fp_enable_out), .bias_pin_input_out(bias_pin_input_out),
  .ladder_connect_out(ladder_connect_out), .ladder_strength_out(ladder_strength_out),
  .frame_done_out(frame_done_out)
);
`default_nettype wire

/* File: sim/lcdgd_glass.sv */
// Glass model that integrates the voltage across one picture element per frame
`default_nettype none
module lcdgd_glass (
  // Clock and reset
  input  wire logic         clk_in,
  input  wire logic         reset_n_in,
  // Element drive and frame marker
  input  wire logic [1:0]   bp_level_in,
  input  wire logic [1:0]   fp_level_in,
  input  wire logic         frame_done_in,
  // Net charge over the last frame
  output logic signed [31:0] dc_sum_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic signed [31:0] acc_ff;
  // net element voltage
  // Residual DC ages the crystal, so a whole frame must sum to nothing
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      acc_ff     <= 32'sh0;
      dc_sum_out <= 32'sh0;
    end else if (frame_done_in) begin
      acc_ff     <= 32'sh0;
      dc_sum_out <= acc_ff + 32'(bp_level_in) - 32'(fp_level_in);
    end else begin
      acc_ff <= acc_ff + 32'(bp_level_in) - 32'(fp_level_in);
    end
  end
endmodule
`default_nettype wire

/* File: sim/testbench.sv */
// Self-checking bench for the LCD glass driver
`default_nettype none
module testbench;
  import lcdgd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_in = 1'b0;
  logic        reset_n_in = 1'b0;
  logic        psel_in = 1'b0;
  logic        penable_in = 1'b0;
  logic        pwrite_in = 1'b0;
  logic [7:0]  paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0;
  logic        int_osc = 1'b0;
  logic        ext_osc = 1'b0;
  logic [31:0] prdata_out;
  logic        pready_out, pslverr_out, ladder_connect_out, bias_half_out, charge_pump_enable_out;
  logic        frame_done_out;
  logic [15:0] bp_level_out;
  logic [7:0]  bp_enable_out;
  logic [79:0] fp_level_out;
  logic [39:0] fp_enable_out;
  logic [3:0]  bias_pin_input_out;
  logic [2:0]  ladder_strength_out;
  logic [1:0]  pump_clock_select_out;
  logic signed [31:0] dc_sum;
  int          n_fail = 0;
  int          check_count = 0;
  lcdgd_top u_dut (.clk_in, .reset_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
    .prdata_out, .pready_out, .pslverr_out, .internal_slow_oscillator_in(int_osc),
    .external_slow_oscillator_in(ext_osc), .bp_level_out, .bp_enable_out, .fp_level_out,
    .fp_enable_out, .bias_pin_input_out, .ladder_connect_out, .ladder_strength_out, .bias_half_out,
    .charge_pump_enable_out, .pump_clock_select_out, .frame_done_out);
  lcdgd_glass u_glass (.clk_in, .reset_n_in, .bp_level_in(bp_level_out[1:0]),
    .fp_level_in(fp_level_out[1:0]), .frame_done_in(frame_done_out), .dc_sum_out(dc_sum));
  // System clock and two unrelated slow oscillators, shortened to keep frames brief
  always #2 clk_in = ~clk_in;
  always #12 int_osc = ~int_osc;
  always #16 ext_osc = ~ext_osc;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // Bus master: hold the request until ready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clk_in);
    psel_in    <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in  <= w;
    paddr_in   <= a;
    pwdata_in  <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    @(posedge clk_in iff pready_out === 1'b1);
    r = prdata_out;
    e = pslverr_out;
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic t_regs();
    logic [31:0] r;
    logic        e;
    apb(1'b0, LCDGD_OFS_CTRL0, 32'h0, r, e);
    chk(r, LCDGD_C0_RESET, "control reset");
    wr(LCDGD_OFS_CTRL0, 32'h27);
    wr(LCDGD_OFS_PINA, 32'h00ff_ffff);
    wr(LCDGD_OFS_PINB, 32'hffff_ffff);
    apb(1'b0, LCDGD_OFS_PINB, 32'h0, r, e);
    chk(r, LCDGD_PB_MASK, "pin b readback");
    chk(32'(fp_enable_out[23:0]), 32'h00ff_ffff, "frontplane enables");
    chk(32'(bp_enable_out[3:0]), 32'hf, "backplane enables");
    apb(1'b0, 8'h18, 32'h0, r, e);
    chk({r[30:0], e}, 32'h1, "unmapped read");
    // Light the first element so the glass sees both drive polarities
    wr(LCDGD_OFS_DATA0, 32'h0000_0001);
  endtask
  task automatic t_ladder();
    logic [2:0] codes[5] = '{3'h7, 3'h1, 3'h2, 3'h4, 3'h0};
    logic [2:0] c;
    wr(LCDGD_OFS_PINA, 32'hffff_ffff);
    foreach (codes[i]) begin
      c = codes[i];
      wr(LCDGD_OFS_CTRL0, {21'h0, 2'h1, c == 3'h0, c, c[0], LCDGD_DUTY_QUART, 1'b1});
      repeat (3) @(posedge clk_in);
      chk(32'(ladder_strength_out), 32'(c), "strength");
      chk(32'(ladder_connect_out), 32'(c != 3'h0), "ladder link");
      chk(32'(bias_pin_input_out), c == 3'h0 ? 32'hf : 32'h0, "bias inputs");
      chk(32'(fp_enable_out[27:24]), c == 3'h0 ? 32'h0 : 32'hf, "freed bias pins");
      chk(32'({bias_half_out, charge_pump_enable_out, pump_clock_select_out}),
          {28'h0, c[0], c == 3'h0, 2'h1}, "bias and pump");
    end
    wr(LCDGD_OFS_PINB, 32'h0f00_00ff);
    repeat (3) @(posedge clk_in);
    chk(32'({bias_pin_input_out, fp_enable_out[27:24]}), 32'h0, "group off");
  endtask
  task automatic t_frame(input logic [2:0] duty, input int nbp, input logic src,
                         input logic [1:0] rate, input int half, input int per);
    int     q[$];
    int     last;
    longint t0;
    wr(LCDGD_OFS_CTRL1, {28'h0, 1'b1, rate, src});
    // bias cleared for static, one-half only with two or three planes
    wr(LCDGD_OFS_CTRL0, {27'h0, nbp == 2 || nbp == 3, duty, 1'b1});
    // The first frame after a change may be mixed, so skip two frames and measure the third
    repeat (2) @(posedge clk_in iff frame_done_out === 1'b1);
    t0 = $time;
    last = -1;
    do begin
      @(posedge clk_in);
      for (int b = 0; b < 8; b++) begin
        if (bp_level_out[2*b+:2] === LCDGD_LVL_V3 && b != last) begin
          q.push_back(b);
          last = b;
        end
      end
    end while (frame_done_out !== 1'b1);
    chk(32'($time - t0), 32'(nbp * 8 * half * per), "frame length");
    chk(32'(q.size() >= nbp), 32'h1, "strobe count");
    for (int i = 0; i < nbp; i++) begin
      chk(32'(q[i]), 32'(i), "strobe order");
    end
    @(negedge clk_in);
    chk(dc_sum, 32'h0, "net element charge");
  endtask
  task automatic t_reserved();
    logic [31:0] r;
    logic        e;
    for (int i = 4; i < 7; i += 2) begin
      wr(LCDGD_OFS_CTRL0, {28'h0, 3'(i), 1'b1});
      repeat (4) @(posedge clk_in);
      chk(32'(|{bp_level_out, fp_level_out, frame_done_out}), 32'h0, "reserved duty idle");
      apb(1'b0, LCDGD_OFS_STAT, 32'h0, r, e);
      chk(32'(r[LCDGD_ST_RUN]), 32'h0, "reserved duty scanning");
    end
  endtask
  initial begin
    repeat (5) @(posedge clk_in);
    reset_n_in <= 1'b1;
    t_regs();
    t_ladder();
    t_frame(LCDGD_DUTY_QUART, 4, 1'b0, 2'h2, 32, 6);
    t_frame(LCDGD_DUTY_EIGHTH, 8, 1'b1, 2'h2, 32, 8);
    t_frame(LCDGD_DUTY_SIXTH, 6, 1'b1, 2'h2, 32, 8);
    t_frame(LCDGD_DUTY_HALF, 2, 1'b0, 2'h1, 64, 6);
    t_frame(LCDGD_DUTY_THIRD, 3, 1'b0, 2'h1, 64, 6);
    t_frame(LCDGD_DUTY_STATIC, 1, 1'b0, 2'h0, 128, 6);
    t_frame(LCDGD_DUTY_STATIC, 1, 1'b0, 2'h3, 256, 6);
    t_reserved();
    tally_and_finish();
  end
  // Watchdog: all frames together take about 206 us
  initial begin
    #400_000;
    n_fail++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
